// ===== cfgcrc_pkg.sv
// cfgcrc_pkg: constants and types of the configuration checksum block.
// assumes a single 20 MHz clock domain and AHB-Lite register access.
`default_nettype none

package cfgcrc_pkg;

  // ==========================================================
  // crc engine
  localparam int CRC_W = 32;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_PRESET = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESET_VALUE = 32'h6BF87803;
  localparam int STREAM_BITS = 2400;
  localparam int CFG_WORDS = STREAM_BITS / 32;
  localparam logic [11:0] LAST_BIT = 12'h95F;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam int IDX_W = 16;
  localparam logic [15:0] IDX_STATUS_SECOND = 16'hE503;
  localparam logic [15:0] IDX_CHECKSUM = 16'hE532;
  localparam logic [15:0] IDX_INT_ENABLE_SECOND = 16'hE540;
  localparam logic [15:0] IDX_CONTROL = 16'hE541;
  localparam logic [15:0] IDX_CFG_BASE = 16'hE600;

  // ==========================================================
  // field positions
  localparam int FLAG_CRC_CHANGE_BIT = 25;
  localparam int CTRL_SOFT_RESET_BIT = 0;

  // ==========================================================
  // bus encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  typedef enum logic [1:0] {
    SEQ_PRESET,
    SEQ_FEED,
    SEQ_LATCH
  } cfgcrc_seq_type;

endpackage

`default_nettype wire

// ===== cfgcrc_lfsr.sv
// cfgcrc_lfsr: serial crc shift register, one input bit per enabled cycle.
// assumes preset and shift_en come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module cfgcrc_lfsr #(
  parameter int WIDTH = cfgcrc_pkg::CRC_W,
  parameter logic [WIDTH-1:0] POLY = cfgcrc_pkg::CRC_POLY,
  parameter logic [WIDTH-1:0] PRESET = cfgcrc_pkg::CRC_PRESET
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic preset,
  input wire logic shift_en,
  input wire logic bit_in,
  // result
  output logic [WIDTH-1:0] crc
);

  typedef struct packed {
    logic [WIDTH-1:0] crc;
  } cfgcrc_lfsr_state_type;

  cfgcrc_lfsr_state_type q;
  cfgcrc_lfsr_state_type d;
  logic fb;

  if (WIDTH < 2) begin : g_width_check
    $error("cfgcrc_lfsr: WIDTH must be at least 2");
  end

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    fb = bit_in ^ q.crc[WIDTH-1];
    if (preset) begin
      d.crc = PRESET;
    end else if (shift_en) begin
      d.crc[0] = fb & POLY[0];
      for (int i = 1; i < WIDTH; i++) begin
        d.crc[i] = (fb & POLY[i]) ^ q.crc[i-1];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{crc: PRESET};
    end else begin
      q <= d;
    end
  end

  assign crc = q.crc;

  // ==========================================================
  // checks
  property p_preset_all_ones;
    @(posedge hclk) disable iff (!hresetn)
    preset |=> crc == PRESET;
  endproperty
  a_preset_all_ones: assert property (p_preset_all_ones) else $error("crc not preset to all ones");

  property p_first_step;
    @(posedge hclk) disable iff (!hresetn)
    preset ##1 (shift_en && !preset && !bit_in) |=> crc == ((PRESET << 1) ^ POLY);
  endproperty
  a_first_step: assert property (p_first_step) else $error("first feedback step wrong");

endmodule

`default_nettype wire

// ===== cfgcrc_irq.sv
// cfgcrc_irq: sticky checksum-change flag, its enable bit and the interrupt line.
// assumes all strobes are single-cycle pulses from the same clock.
`timescale 1ns/1ps
`default_nettype none

module cfgcrc_irq (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // events and software access
  input wire logic flag_set,
  input wire logic flag_clear,
  input wire logic enable_wr,
  input wire logic enable_data,
  input wire logic soft_rst,
  // state
  output logic flag,
  output logic enable,
  output logic irq_n
);

  typedef struct packed {
    logic flag;
    logic enable;
    logic irq_n;
  } cfgcrc_irq_state_type;

  cfgcrc_irq_state_type q;
  cfgcrc_irq_state_type d;

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    if (soft_rst) begin
      d.flag = 1'b0;
      d.enable = 1'b0;
    end else begin
      if (enable_wr) begin
        d.enable = enable_data;
      end
      d.flag = flag_set | (q.flag & ~flag_clear);
    end
    d.irq_n = ~(d.flag & d.enable);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{flag: 1'b0, enable: 1'b0, irq_n: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign flag = q.flag;
  assign enable = q.enable;
  assign irq_n = q.irq_n;

  // ==========================================================
  // checks
  property p_set_wins;
    @(posedge hclk) disable iff (!hresetn)
    (flag_set && !soft_rst) |=> flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag lost on set");

  property p_irq_level;
    @(posedge hclk) disable iff (!hresetn)
    (flag_set && !soft_rst && (enable_wr ? enable_data : enable)) |=> !irq_n;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt line wrong");

  property p_clear_release;
    @(posedge hclk) disable iff (!hresetn)
    (flag_clear && !flag_set && flag) |=> !flag && irq_n;
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("clear did not release");

  c_irq_low: cover property (@(posedge hclk) disable iff (!hresetn) $fell(irq_n));

endmodule

`default_nettype wire

// ===== cfgcrc_top.sv
// cfgcrc_top: configuration image, checksum scanner and AHB-Lite register slave.
// assumes one AHB-Lite master and this slave alone, so hready equals hreadyout.
// How it works
// - a 32-bit readable checksum covers all configuration and reserved words.
// - checksum is the 802.3 crc, registers fed serially, lsb first.
// - stream is 2400 bits, first lsb of first word, last msb of last.
// - all 32 shift register bits start at one before the first bit.
// - feedback taps only at 0,1,2,4,5,7,8,10,11,12,16,22,23,26.
// - feedback is input xor bit 31, shifted into bit zero upward.
// - a hardware reset loads CRC_RESET_VALUE into the checksum; a soft reset keeps the old checksum until the next pass latches.
// - a write of a writable word or a silent change of a covered word sets flag bit 25.
// - flag set with enable bit 25 set drives the interrupt line low.
// - writing one to the flag clears it and releases the interrupt.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module cfgcrc_top #(
  parameter logic [cfgcrc_pkg::STREAM_BITS-1:0] DEFAULT_IMAGE = '0,
  parameter int NUM_WRITABLE = 64
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // interrupt
  output logic interrupt_out_second_n
);

  localparam int NB = cfgcrc_pkg::STREAM_BITS;
  localparam int NW = cfgcrc_pkg::CFG_WORDS;

  if (NUM_WRITABLE < 1 || NUM_WRITABLE > NW) begin : g_param_check
    $error("cfgcrc_top: NUM_WRITABLE out of range");
  end

  typedef struct packed {
    logic [NB-1:0] image;
    cfgcrc_pkg::cfgcrc_seq_type seq;
    logic [11:0] bit_cnt;
    logic [31:0] checksum;
    logic primed;
    logic ph_valid;
    logic ph_write;
    logic ph_ok;
    logic [15:0] ph_idx;
    logic rd_done;
    logic [31:0] rdata;
  } cfgcrc_state_type;

  cfgcrc_state_type q;
  cfgcrc_state_type d;

  logic [31:0] lfsr_crc;
  logic flag;
  logic flag_enable;
  logic flag_set;
  logic flag_clear;
  logic enable_wr;
  logic soft_rst;
  logic cfg_wr;
  logic wr_now;
  logic new_ap;
  int word;

  // ==========================================================
  // address helpers
  function automatic logic is_cfg(input logic [15:0] idx);
    return idx >= cfgcrc_pkg::IDX_CFG_BASE && idx < cfgcrc_pkg::IDX_CFG_BASE + 16'(NW);
  endfunction

  function automatic logic is_cfg_writable(input logic [15:0] idx);
    return idx >= cfgcrc_pkg::IDX_CFG_BASE && idx < cfgcrc_pkg::IDX_CFG_BASE + 16'(NUM_WRITABLE);
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    word = 0;
    d = q;
    flag_set = 1'b0;
    flag_clear = 1'b0;
    enable_wr = 1'b0;
    soft_rst = 1'b0;
    cfg_wr = 1'b0;
    new_ap = hsel && htrans == cfgcrc_pkg::HTRANS_NONSEQ && hready;
    wr_now = q.ph_valid && q.ph_write && q.ph_ok;
    if (is_cfg(q.ph_idx)) begin
      word = int'(q.ph_idx - cfgcrc_pkg::IDX_CFG_BASE);
    end

    // scanner: preset, 2400 shifts, latch
    unique case (q.seq)
      cfgcrc_pkg::SEQ_PRESET: begin
        d.bit_cnt = 12'h000;
        d.seq = cfgcrc_pkg::SEQ_FEED;
      end
      cfgcrc_pkg::SEQ_FEED: begin
        if (q.bit_cnt == cfgcrc_pkg::LAST_BIT) begin
          d.seq = cfgcrc_pkg::SEQ_LATCH;
        end else begin
          d.bit_cnt = q.bit_cnt + 12'h001;
        end
      end
      cfgcrc_pkg::SEQ_LATCH: begin
        d.checksum = lfsr_crc;
        d.primed = 1'b1;
        // a pass that differs from the last one means a word changed silently
        if (q.primed && lfsr_crc != q.checksum) begin
          flag_set = 1'b1;
        end
        d.seq = cfgcrc_pkg::SEQ_PRESET;
      end
    endcase

    // write data phase, zero wait
    if (wr_now) begin
      if (is_cfg_writable(q.ph_idx)) begin
        d.image[word*32 +: 32] = hwdata;
        cfg_wr = 1'b1;
        flag_set = 1'b1;
        d.seq = cfgcrc_pkg::SEQ_PRESET;
        // the pass after a write is a new baseline, not a silent change
        d.primed = 1'b0;
      end
      if (q.ph_idx == cfgcrc_pkg::IDX_STATUS_SECOND) begin
        flag_clear = hwdata[cfgcrc_pkg::FLAG_CRC_CHANGE_BIT];
      end
      if (q.ph_idx == cfgcrc_pkg::IDX_INT_ENABLE_SECOND) begin
        enable_wr = 1'b1;
      end
      if (q.ph_idx == cfgcrc_pkg::IDX_CONTROL && hwdata[cfgcrc_pkg::CTRL_SOFT_RESET_BIT]) begin
        soft_rst = 1'b1;
        d.image = DEFAULT_IMAGE;
        d.primed = 1'b0;
        d.seq = cfgcrc_pkg::SEQ_PRESET;
        flag_set = 1'b0;
      end
    end

    // read data phase, one wait state then data
    if (q.ph_valid && !q.ph_write && !q.rd_done) begin
      d.rd_done = 1'b1;
      d.rdata = 32'h0000_0000;
      if (q.ph_ok) begin
        if (is_cfg(q.ph_idx)) begin
          d.rdata = q.image[word*32 +: 32];
        end
        unique case (q.ph_idx)
          cfgcrc_pkg::IDX_CHECKSUM: d.rdata = q.checksum;
          cfgcrc_pkg::IDX_STATUS_SECOND: d.rdata[cfgcrc_pkg::FLAG_CRC_CHANGE_BIT] = flag;
          cfgcrc_pkg::IDX_INT_ENABLE_SECOND: d.rdata[cfgcrc_pkg::FLAG_CRC_CHANGE_BIT] = flag_enable;
          default: d.rdata = d.rdata;
        endcase
      end
    end

    // address phase capture
    if (hready) begin
      d.ph_valid = new_ap;
      d.ph_write = hwrite;
      d.ph_ok = haddr[31:18] == 14'h0000 && haddr[1:0] == 2'h0;
      d.ph_idx = haddr[17:2];
      d.rd_done = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q.image <= DEFAULT_IMAGE;
      q.seq <= cfgcrc_pkg::SEQ_PRESET;
      q.bit_cnt <= 12'h000;
      q.checksum <= cfgcrc_pkg::CRC_RESET_VALUE;
      q.primed <= 1'b0;
      q.ph_valid <= 1'b0;
      q.ph_write <= 1'b0;
      q.ph_ok <= 1'b0;
      q.ph_idx <= 16'h0000;
      q.rd_done <= 1'b0;
      q.rdata <= 32'h0000_0000;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // crc engine and interrupt
  cfgcrc_lfsr #(
    .WIDTH(cfgcrc_pkg::CRC_W),
    .POLY(cfgcrc_pkg::CRC_POLY),
    .PRESET(cfgcrc_pkg::CRC_PRESET)
  ) u_lfsr (
    .hclk(hclk),
    .hresetn(hresetn),
    .preset(q.seq == cfgcrc_pkg::SEQ_PRESET),
    .shift_en(q.seq == cfgcrc_pkg::SEQ_FEED),
    .bit_in(q.image[q.bit_cnt]),
    .crc(lfsr_crc)
  );

  cfgcrc_irq u_irq (
    .hclk(hclk),
    .hresetn(hresetn),
    .flag_set(flag_set),
    .flag_clear(flag_clear),
    .enable_wr(enable_wr),
    .enable_data(hwdata[cfgcrc_pkg::FLAG_CRC_CHANGE_BIT]),
    .soft_rst(soft_rst),
    .flag(flag),
    .enable(flag_enable),
    .irq_n(interrupt_out_second_n)
  );

  // ==========================================================
  // bus outputs
  assign hreadyout = !(q.ph_valid && !q.ph_write && !q.rd_done);
  assign hresp = cfgcrc_pkg::HRESP_OKAY;
  assign hrdata = q.rdata;

  // ==========================================================
  // checks
  property p_pass_length;
    @(posedge hclk) disable iff (!hresetn)
    q.seq == cfgcrc_pkg::SEQ_LATCH |-> $past(q.bit_cnt) == cfgcrc_pkg::LAST_BIT;
  endproperty
  a_pass_length: assert property (p_pass_length) else $error("pass not 2400 bits");

  property p_latch_result;
    @(posedge hclk) disable iff (!hresetn)
    q.seq == cfgcrc_pkg::SEQ_LATCH |=> q.checksum == $past(lfsr_crc);
  endproperty
  a_latch_result: assert property (p_latch_result) else $error("checksum not latched");

  property p_checksum_ro;
    @(posedge hclk) disable iff (!hresetn)
    (wr_now && q.ph_idx == cfgcrc_pkg::IDX_CHECKSUM && q.seq != cfgcrc_pkg::SEQ_LATCH) |=> $stable(q.checksum);
  endproperty
  a_checksum_ro: assert property (p_checksum_ro) else $error("checksum changed by write");

  property p_write_flags;
    @(posedge hclk) disable iff (!hresetn)
    (cfg_wr && !soft_rst) |=> flag ##1 (q.seq == cfgcrc_pkg::SEQ_FEED);
  endproperty
  a_write_flags: assert property (p_write_flags) else $error("write did not flag and restart");

  property p_soft_reset;
    @(posedge hclk) disable iff (!hresetn)
    soft_rst |=> q.image == DEFAULT_IMAGE && !flag && q.seq == cfgcrc_pkg::SEQ_PRESET;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

  property p_read_checksum;
    @(posedge hclk) disable iff (!hresetn)
    (q.ph_valid && !q.ph_write && !q.rd_done && q.ph_ok && q.ph_idx == cfgcrc_pkg::IDX_CHECKSUM)
      |=> hreadyout && hrdata == $past(q.checksum);
  endproperty
  a_read_checksum: assert property (p_read_checksum) else $error("checksum read wrong");

  property p_first_pass_quiet;
    @(posedge hclk) disable iff (!hresetn)
    (q.seq == cfgcrc_pkg::SEQ_LATCH && !q.primed && !cfg_wr) |-> !flag_set;
  endproperty
  a_first_pass_quiet: assert property (p_first_pass_quiet) else $error("baseline pass raised flag");

  property p_preset_start;
    @(posedge hclk) disable iff (!hresetn)
    (q.seq == cfgcrc_pkg::SEQ_FEED && q.bit_cnt == 12'h000) |-> lfsr_crc == cfgcrc_pkg::CRC_PRESET;
  endproperty
  a_preset_start: assert property (p_preset_start) else $error("pass did not start from all ones");

  property p_reserved_fixed;
    @(posedge hclk) disable iff (!hresetn)
    (wr_now && is_cfg(q.ph_idx) && !is_cfg_writable(q.ph_idx)) |=> $stable(q.image);
  endproperty
  a_reserved_fixed: assert property (p_reserved_fixed) else $error("reserved word changed");

  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn)
    (new_ap && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

  c_soft_reset: cover property (@(posedge hclk) disable iff (!hresetn) soft_rst);
  c_cfg_write: cover property (@(posedge hclk) disable iff (!hresetn) cfg_wr);
  c_silent_change: cover property (@(posedge hclk) disable iff (!hresetn)
    q.seq == cfgcrc_pkg::SEQ_LATCH && q.primed && lfsr_crc != q.checksum);

endmodule

`default_nettype wire

// ===== tb_cfgcrc_top.sv
// tb_cfgcrc_top: self-checking bench for the configuration checksum block.
// assumes cfgcrc_pkg is compiled first; drives the ahb-lite slave directly.
`timescale 1ns/1ps
`default_nettype none

module tb_cfgcrc_top;
  // ==========================================================
  // signals
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = cfgcrc_pkg::HTRANS_IDLE;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic interrupt_out_second_n;
  logic [31:0] img [75];
  logic [31:0] rd;
  int error_cnt = 0;
  int num_checks = 0;
  localparam logic [31:0] TAPS = 32'h04C11DB7;
  localparam logic [31:0] FLAG = 32'h02000000;

  always #25 hclk = ~hclk;
  assign hready = hreadyout;

  cfgcrc_top cfgcrc_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .interrupt_out_second_n(interrupt_out_second_n)
  );

  // ==========================================================
  // reference checksum over the bench's copy of the image
  function automatic logic [31:0] crc_img();
    logic [31:0] b;
    logic fb;
    b = 32'hFFFFFFFF;
    for (int k = 0; k < 2400; k++) begin
      fb = img[k / 32][k % 32] ^ b[31];
      b = {b[30:0], 1'b0} ^ (fb ? TAPS : 32'h0);
    end
    return b;
  endfunction

  // ==========================================================
  // checking and closing
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // one ahb-lite single transfer; ready sampled on the falling edge before each rising edge
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] r);
    logic rdy;
    int waits;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'h0};
    htrans <= cfgcrc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      @(posedge hclk);
    end while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= cfgcrc_pkg::HTRANS_IDLE;
    hwdata <= wd;
    waits = 0;
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      r = hrdata;
      check("hresp", {31'h0, hresp}, {31'h0, cfgcrc_pkg::HRESP_OKAY});
      if (rdy !== 1'b1) begin
        waits++;
      end
      @(posedge hclk);
    end while (rdy !== 1'b1);
    check("data phase waits", 32'(waits), w ? 32'h0 : 32'h1);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, idx, wd, dummy);
  endtask

  task automatic rd_chk(input string what, input logic [15:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0, rd);
    check(what, rd, exp);
  endtask

  task automatic irq_chk(input logic exp);
    repeat (2) @(negedge hclk);
    check("irq_n", {31'h0, interrupt_out_second_n}, {31'h0, exp});
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_values();
    rd_chk("checksum reset", cfgcrc_pkg::IDX_CHECKSUM, cfgcrc_pkg::CRC_RESET_VALUE);
    rd_chk("status reset", cfgcrc_pkg::IDX_STATUS_SECOND, 32'h0);
    rd_chk("enable reset", cfgcrc_pkg::IDX_INT_ENABLE_SECOND, 32'h0);
    rd_chk("unmapped read", 16'h0123, 32'h0);
    irq_chk(1'b1);
  endtask

  task automatic t_default_pass();
    repeat (2500) @(posedge hclk);
    rd_chk("default checksum", cfgcrc_pkg::IDX_CHECKSUM, crc_img());
    rd_chk("no flag first pass", cfgcrc_pkg::IDX_STATUS_SECOND, 32'h0);
  endtask

  task automatic t_write_flag_irq();
    img[5] = 32'hA5C30F81;
    img[63] = 32'h80000001;
    wr(cfgcrc_pkg::IDX_CFG_BASE + 16'h5, img[5]);
    wr(cfgcrc_pkg::IDX_CFG_BASE + 16'h3F, img[63]);
    rd_chk("flag after write", cfgcrc_pkg::IDX_STATUS_SECOND, FLAG);
    irq_chk(1'b1);
    rd_chk("word readback", cfgcrc_pkg::IDX_CFG_BASE + 16'h5, img[5]);
    wr(cfgcrc_pkg::IDX_CHECKSUM, 32'h12345678);
    repeat (2500) @(posedge hclk);
    rd_chk("recomputed checksum", cfgcrc_pkg::IDX_CHECKSUM, crc_img());
    wr(cfgcrc_pkg::IDX_INT_ENABLE_SECOND, FLAG);
    irq_chk(1'b0);
    wr(cfgcrc_pkg::IDX_STATUS_SECOND, 32'h0);
    rd_chk("flag kept on zero", cfgcrc_pkg::IDX_STATUS_SECOND, FLAG);
    wr(cfgcrc_pkg::IDX_STATUS_SECOND, FLAG);
    rd_chk("flag cleared", cfgcrc_pkg::IDX_STATUS_SECOND, 32'h0);
    irq_chk(1'b1);
  endtask

  task automatic t_clear_after_write();
    img[7] = 32'h3C00F00D;
    wr(cfgcrc_pkg::IDX_CFG_BASE + 16'h7, img[7]);
    wr(cfgcrc_pkg::IDX_STATUS_SECOND, FLAG);
    repeat (2500) @(posedge hclk);
    rd_chk("no flag after cleared write", cfgcrc_pkg::IDX_STATUS_SECOND, 32'h0);
    irq_chk(1'b1);
    rd_chk("checksum after write", cfgcrc_pkg::IDX_CHECKSUM, crc_img());
  endtask

  task automatic t_hw_reset();
    wr(cfgcrc_pkg::IDX_CFG_BASE + 16'h9, 32'h5A5A5A5A);
    wr(cfgcrc_pkg::IDX_INT_ENABLE_SECOND, FLAG);
    irq_chk(1'b0);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("checksum after hw reset", cfgcrc_pkg::IDX_CHECKSUM, cfgcrc_pkg::CRC_RESET_VALUE);
    rd_chk("word after hw reset", cfgcrc_pkg::IDX_CFG_BASE + 16'h9, 32'h0);
    rd_chk("status after hw reset", cfgcrc_pkg::IDX_STATUS_SECOND, 32'h0);
    rd_chk("enable after hw reset", cfgcrc_pkg::IDX_INT_ENABLE_SECOND, 32'h0);
    irq_chk(1'b1);
  endtask

  task automatic t_reserved_word();
    wr(cfgcrc_pkg::IDX_CFG_BASE + 16'h40, 32'hFFFFFFFF);
    rd_chk("reserved readback", cfgcrc_pkg::IDX_CFG_BASE + 16'h40, 32'h0);
    repeat (2500) @(posedge hclk);
    rd_chk("no flag reserved", cfgcrc_pkg::IDX_STATUS_SECOND, 32'h0);
    rd_chk("checksum steady", cfgcrc_pkg::IDX_CHECKSUM, crc_img());
  endtask

  task automatic t_soft_reset();
    wr(cfgcrc_pkg::IDX_CFG_BASE + 16'h2, 32'h00C0FFEE);
    wr(cfgcrc_pkg::IDX_CONTROL, 32'h1);
    for (int i = 0; i < 75; i++) begin
      img[i] = 32'h0;
    end
    rd_chk("status after soft reset", cfgcrc_pkg::IDX_STATUS_SECOND, 32'h0);
    rd_chk("enable after soft reset", cfgcrc_pkg::IDX_INT_ENABLE_SECOND, 32'h0);
    rd_chk("word after soft reset", cfgcrc_pkg::IDX_CFG_BASE + 16'h5, 32'h0);
    irq_chk(1'b1);
    repeat (2500) @(posedge hclk);
    rd_chk("checksum after soft reset", cfgcrc_pkg::IDX_CHECKSUM, crc_img());
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    for (int i = 0; i < 75; i++) begin
      img[i] = 32'h0;
    end
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_values();
    t_default_pass();
    t_write_flag_irq();
    t_clear_after_write();
    t_reserved_word();
    t_soft_reset();
    t_hw_reset();
    report_and_stop();
  end

  initial begin
    repeat (40000) @(posedge hclk);
    error_cnt++;
    report_and_stop();
  end
endmodule

`default_nettype wire
